// *** src/process_value_alarm_scaling_logic.sv ***
// Top: process-value scaling, square-root switch, four limit alarms, inrush start,
// output hold on host faults and adjustment-date start-up from nonvolatile storage.
// Assumes one 50 MHz clock, inputs synchronous to it, raw_valid one cycle per conversion.
//
// Function
// - Alarm stays off if condition drops early
// - Alarm stays on if off condition drops early
// - Reversed range maps input linearly, reversed
// - Alarms compare the scaled process value
// - Upper alarms trip on value above set
// - Lower alarms trip on value below set
// - Disconnect, overrange high forces range maximum
// - Disconnect, overrange low forces range minimum
// - Host faults hold preset or last output
// - Normal host resumes host word output
// - Previous hold under rate limit freezes output
// - Preset hold still obeys rate limit
// - Inrush disabled if above 2% at start
// - Inrush engages only on upward 2% crossing
// - Square-root mode passes input in low region
// - Rising input enters square root at 0.5%
// - Falling input returns linear at 0.3%
// - No stored date: all ones, notice, ended
// - Faulty date: error flag, all ones, bits
// - Storage fault lights lamp, suspends adjustment
// - Raised upper set clears below set minus hysteresis
// - Lowered lower set clears above set plus hysteresis
`timescale 1ns/10ps
module process_value_alarm_scaling_logic #(
  parameter int OUT_DIV = pv_post_pkg::OUT_DIV_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        raw_valid,
  input  wire logic [15:0] raw_value,
  input  wire logic        input_disconnect,
  input  wire logic        host_fatal,
  input  wire logic        user_fatal_instruction,
  input  wire logic        host_cpu_error,
  input  wire logic        load_break,
  input  wire logic [15:0] host_io_word_area,
  input  wire logic        nv_done,
  input  wire logic        nv_present,
  input  wire logic        nv_fault,
  input  wire logic [31:0] nv_date,
  output logic [15:0]      pv_out,
  output logic             upper_upper_alarm,
  output logic             upper_alarm,
  output logic             lower_alarm,
  output logic             lower_lower_alarm,
  output logic             inrush_start,
  output logic [15:0]      analog_out,
  output logic             config_error_lamp
);

  if (OUT_DIV < 2) begin : g_chk
    $error("OUT_DIV must be at least 2");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0]  ctrl_q;
  logic [15:0] range_max_q;
  logic [15:0] range_min_q;
  logic [15:0] sv_q [4];
  logic [15:0] hyst_q;
  logic [7:0]  on_dly_q;
  logic [7:0]  off_dly_q;
  logic [15:0] preset_q;
  logic [15:0] rate_q;
  logic [15:0] rdata_q;
  logic [15:0] status_w;
  logic [3:0]  alarm_w;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_q      <= 4'h0;
      range_max_q <= pv_post_pkg::RST_RANGE_MAX;
      range_min_q <= pv_post_pkg::RST_RANGE_MIN;
      sv_q[0]     <= pv_post_pkg::RST_SV_UP;
      sv_q[1]     <= pv_post_pkg::RST_SV_UP;
      sv_q[2]     <= pv_post_pkg::RST_SV_LO;
      sv_q[3]     <= pv_post_pkg::RST_SV_LO;
      hyst_q      <= 16'h0000;
      on_dly_q    <= 8'h00;
      off_dly_q   <= 8'h00;
      preset_q    <= 16'h0000;
      rate_q      <= 16'hffff;
    end else if (reg_wr) begin
      unique case (reg_addr)
        pv_post_pkg::REG_CTRL:      ctrl_q      <= reg_wdata[3:0];
        pv_post_pkg::REG_RANGE_MAX: range_max_q <= reg_wdata;
        pv_post_pkg::REG_RANGE_MIN: range_min_q <= reg_wdata;
        pv_post_pkg::REG_HYST:      hyst_q      <= reg_wdata;
        pv_post_pkg::REG_ON_DLY:    on_dly_q    <= reg_wdata[7:0];
        pv_post_pkg::REG_OFF_DLY:   off_dly_q   <= reg_wdata[7:0];
        pv_post_pkg::REG_PRESET:    preset_q    <= reg_wdata;
        pv_post_pkg::REG_RATE:      rate_q      <= reg_wdata;
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (reg_addr == 5'(pv_post_pkg::REG_SV_BASE + 5'(i))) begin
              sv_q[i] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Square-root switch and scaling
  // ****************************************
  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] r;
    logic [15:0] t;
    r = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      t = r | (16'h0001 << i);
      if ({16'h0000, t} * {16'h0000, t} <= v) begin
        r = t;
      end
    end
    return r;
  endfunction

  logic               sqrt_mode_q;
  logic               sqrt_mode_d;
  logic [15:0]        frac_w;
  logic signed [16:0] span_w;
  logic signed [33:0] prod_w;
  logic [15:0]        scaled_w;
  logic [15:0]        pv_q;
  logic [15:0]        frac_q;
  logic               tick_q;

  always_comb begin
    sqrt_mode_d = sqrt_mode_q;
    if (!ctrl_q[pv_post_pkg::CTRL_SQRT_EN]) begin
      sqrt_mode_d = 1'b0;
    end else if (!sqrt_mode_q && raw_value >= pv_post_pkg::SQRT_ON_LVL) begin
      sqrt_mode_d = 1'b1;
    end else if (sqrt_mode_q && raw_value <= pv_post_pkg::SQRT_OFF_LVL) begin
      sqrt_mode_d = 1'b0;
    end
  end

  // Low region stays linear so noise near zero is not magnified
  assign frac_w   = sqrt_mode_d ? isqrt({raw_value, 16'h0000}) : raw_value;
  assign span_w   = 17'(signed'(range_max_q)) - 17'(signed'(range_min_q));
  assign prod_w   = 34'(signed'({1'b0, frac_w})) * 34'(span_w);
  assign scaled_w = 16'(range_min_q + 16'(prod_w >>> pv_post_pkg::FRAC_BITS));

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sqrt_mode_q <= 1'b0;
    end else if (raw_valid) begin
      sqrt_mode_q <= sqrt_mode_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pv_q   <= 16'h0000;
      frac_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= raw_valid;
      if (raw_valid) begin
        frac_q <= frac_w;
        if (input_disconnect) begin
          pv_q <= ctrl_q[pv_post_pkg::CTRL_OVR_HIGH] ? range_max_q : range_min_q;
        end else begin
          pv_q <= scaled_w;
        end
      end
    end
  end

  // ****************************************
  // Limit alarms
  // ****************************************
  alarm_if ach [4] ();

  for (genvar g = 0; g < 4; g++) begin : g_alarm
    assign ach[g].tick    = tick_q;
    assign ach[g].upper   = (g < 2);
    assign ach[g].pv      = pv_q;
    assign ach[g].sv      = sv_q[g];
    assign ach[g].hyst    = hyst_q;
    assign ach[g].on_dly  = on_dly_q;
    assign ach[g].off_dly = off_dly_q;
    assign alarm_w[g]     = ach[g].alarm;
    limit_alarm u_alarm (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .a       (ach[g])
    );
  end

  // ****************************************
  // Inrush start detection
  // ****************************************
  logic seen_q;
  logic armed_q;
  logic inrush_q;

  // One engagement per power cycle; a start above threshold never arms
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seen_q   <= 1'b0;
      armed_q  <= 1'b0;
      inrush_q <= 1'b0;
    end else begin
      inrush_q <= 1'b0;
      if (tick_q) begin
        if (!seen_q) begin
          seen_q  <= 1'b1;
          armed_q <= (frac_q <= pv_post_pkg::INRUSH_LVL);
        end else if (armed_q && frac_q > pv_post_pkg::INRUSH_LVL) begin
          armed_q  <= 1'b0;
          inrush_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Output channel with hold and rate limit
  // ****************************************
  localparam int DCW = $clog2(OUT_DIV);
  logic [DCW-1:0]     div_q;
  logic               out_tick_q;
  logic               fault_w;
  logic [15:0]        target_w;
  logic signed [17:0] diff_w;
  logic signed [17:0] step_w;
  logic [15:0]        ao_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_q      <= '0;
      out_tick_q <= 1'b0;
    end else begin
      out_tick_q <= (div_q == DCW'(OUT_DIV - 1));
      div_q      <= (div_q == DCW'(OUT_DIV - 1)) ? '0 : div_q + DCW'(1);
    end
  end

  assign fault_w = host_fatal | user_fatal_instruction | host_cpu_error | load_break;

  always_comb begin
    if (!fault_w) begin
      target_w = host_io_word_area;
    end else if (ctrl_q[pv_post_pkg::CTRL_HOLD_PRE]) begin
      target_w = preset_q;
    end else begin
      target_w = ao_q;
    end
    diff_w = 18'(signed'(target_w)) - 18'(signed'(ao_q));
    step_w = diff_w;
    if (ctrl_q[pv_post_pkg::CTRL_RATE_EN]) begin
      if (diff_w > signed'(18'(rate_q))) begin
        step_w = signed'(18'(rate_q));
      end else if (diff_w < -signed'(18'(rate_q))) begin
        step_w = -signed'(18'(rate_q));
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ao_q <= 16'h0000;
    end else if (out_tick_q) begin
      ao_q <= 16'(18'(signed'(ao_q)) + step_w);
    end
  end

  // ****************************************
  // Adjustment date start-up
  // ****************************************
  logic [31:0] date_q;
  logic        nv_err_q;
  logic        notice_q;
  logic        ended_q;
  logic        suspend_q;
  logic        lamp_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      date_q    <= pv_post_pkg::DATE_BLANK;
      nv_err_q  <= 1'b0;
      notice_q  <= 1'b0;
      ended_q   <= 1'b0;
      suspend_q <= 1'b0;
      lamp_q    <= 1'b0;
    end else if (nv_done) begin
      if (nv_fault) begin
        nv_err_q  <= 1'b1;
        date_q    <= pv_post_pkg::DATE_BLANK;
        notice_q  <= 1'b1;
        ended_q   <= 1'b1;
        suspend_q <= 1'b1;
        lamp_q    <= 1'b1;
      end else if (!nv_present) begin
        date_q   <= pv_post_pkg::DATE_BLANK;
        notice_q <= 1'b1;
        ended_q  <= 1'b1;
      end else begin
        date_q   <= nv_date;
        notice_q <= 1'b0;
        ended_q  <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  assign status_w = {5'h00, fault_w, suspend_q, ended_q, notice_q, nv_err_q, armed_q, sqrt_mode_q, alarm_w};

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pv_post_pkg::REG_CTRL:      rdata_q <= {12'h000, ctrl_q};
        pv_post_pkg::REG_RANGE_MAX: rdata_q <= range_max_q;
        pv_post_pkg::REG_RANGE_MIN: rdata_q <= range_min_q;
        pv_post_pkg::REG_HYST:      rdata_q <= hyst_q;
        pv_post_pkg::REG_ON_DLY:    rdata_q <= {8'h00, on_dly_q};
        pv_post_pkg::REG_OFF_DLY:   rdata_q <= {8'h00, off_dly_q};
        pv_post_pkg::REG_PRESET:    rdata_q <= preset_q;
        pv_post_pkg::REG_RATE:      rdata_q <= rate_q;
        pv_post_pkg::REG_STATUS:    rdata_q <= status_w;
        pv_post_pkg::REG_PV:        rdata_q <= pv_q;
        pv_post_pkg::REG_DATE_LO:   rdata_q <= date_q[15:0];
        pv_post_pkg::REG_DATE_HI:   rdata_q <= date_q[31:16];
        pv_post_pkg::REG_AO:        rdata_q <= ao_q;
        default: begin
          rdata_q <= 16'h0000;
          for (int i = 0; i < 4; i++) begin
            if (reg_addr == 5'(pv_post_pkg::REG_SV_BASE + 5'(i))) begin
              rdata_q <= sv_q[i];
            end
          end
        end
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata         = rdata_q;
  assign pv_out            = pv_q;
  assign upper_upper_alarm = alarm_w[0];
  assign upper_alarm       = alarm_w[1];
  assign lower_alarm       = alarm_w[2];
  assign lower_lower_alarm = alarm_w[3];
  assign inrush_start      = inrush_q;
  assign analog_out        = ao_q;
  assign config_error_lamp = lamp_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_disc_sample;
    raw_valid && input_disconnect;
  endsequence

  property p_disc_high;
    @(posedge clk_sys) disable iff (!resetn)
      s_disc_sample and ctrl_q[pv_post_pkg::CTRL_OVR_HIGH] |=> pv_q == $past(range_max_q);
  endproperty
  a_disc_high: assert property (p_disc_high) else $error("disconnect did not force maximum");

  property p_disc_low;
    @(posedge clk_sys) disable iff (!resetn)
      s_disc_sample and !ctrl_q[pv_post_pkg::CTRL_OVR_HIGH] |=> pv_q == $past(range_min_q);
  endproperty
  a_disc_low: assert property (p_disc_low) else $error("disconnect did not force minimum");

  property p_sqrt_rise;
    @(posedge clk_sys) disable iff (!resetn)
      raw_valid && ctrl_q[pv_post_pkg::CTRL_SQRT_EN] && raw_value >= pv_post_pkg::SQRT_ON_LVL |=> sqrt_mode_q;
  endproperty
  a_sqrt_rise: assert property (p_sqrt_rise) else $error("square root not entered");

  property p_sqrt_fall;
    @(posedge clk_sys) disable iff (!resetn)
      raw_valid && sqrt_mode_q && raw_value > pv_post_pkg::SQRT_OFF_LVL
        && ctrl_q[pv_post_pkg::CTRL_SQRT_EN] |=> sqrt_mode_q;
  endproperty
  a_sqrt_fall: assert property (p_sqrt_fall) else $error("left square root above low level");

  property p_inrush_cross;
    @(posedge clk_sys) disable iff (!resetn)
      inrush_q |-> $past(armed_q) && $past(frac_q) > pv_post_pkg::INRUSH_LVL && !armed_q;
  endproperty
  a_inrush_cross: assert property (p_inrush_cross) else $error("inrush without upward crossing");

  property p_prev_hold;
    @(posedge clk_sys) disable iff (!resetn)
      fault_w && !ctrl_q[pv_post_pkg::CTRL_HOLD_PRE] ##1 fault_w |-> $stable(ao_q);
  endproperty
  a_prev_hold: assert property (p_prev_hold) else $error("held output moved");

  property p_nv_fault;
    @(posedge clk_sys) disable iff (!resetn)
      nv_done && nv_fault |=> nv_err_q && lamp_q && suspend_q && date_q == pv_post_pkg::DATE_BLANK
        && notice_q && ended_q;
  endproperty
  a_nv_fault: assert property (p_nv_fault) else $error("storage fault start-up wrong");

  property p_nv_blank;
    @(posedge clk_sys) disable iff (!resetn)
      nv_done && !nv_fault && !nv_present |=> date_q == pv_post_pkg::DATE_BLANK && notice_q && ended_q;
  endproperty
  a_nv_blank: assert property (p_nv_blank) else $error("blank date start-up wrong");

endmodule

// *** src/pv_post_pkg.sv ***
// Package: constants shared by the process-value post-processing block.
// Assumes the raw conversion is an unsigned fraction of full scale, FRAC_BITS wide.
package pv_post_pkg;

  // ****************************************
  // Data format
  // ****************************************
  localparam int FRAC_BITS      = 16;
  localparam int FULL_SCALE     = 65536;
  localparam int PERMIL_DIV     = 1000;
  localparam int SQRT_ON_PERMIL = 5;
  localparam int SQRT_OFF_PERMIL = 3;
  localparam int INRUSH_PERMIL  = 20;
  localparam logic [15:0] SQRT_ON_LVL  = 16'((FULL_SCALE * SQRT_ON_PERMIL) / PERMIL_DIV);
  localparam logic [15:0] SQRT_OFF_LVL = 16'((FULL_SCALE * SQRT_OFF_PERMIL) / PERMIL_DIV);
  localparam logic [15:0] INRUSH_LVL   = 16'((FULL_SCALE * INRUSH_PERMIL) / PERMIL_DIV);

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ       = 50;
  localparam int OUT_UPDATE_US = 1000;
  localparam int OUT_DIV_CYC   = OUT_UPDATE_US * CLK_MHZ;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [4:0] REG_CTRL      = 5'h00;
  localparam logic [4:0] REG_RANGE_MAX = 5'h01;
  localparam logic [4:0] REG_RANGE_MIN = 5'h02;
  localparam logic [4:0] REG_SV_BASE   = 5'h03;
  localparam logic [4:0] REG_HYST      = 5'h07;
  localparam logic [4:0] REG_ON_DLY    = 5'h08;
  localparam logic [4:0] REG_OFF_DLY   = 5'h09;
  localparam logic [4:0] REG_PRESET    = 5'h0a;
  localparam logic [4:0] REG_RATE      = 5'h0b;
  localparam logic [4:0] REG_STATUS    = 5'h0c;
  localparam logic [4:0] REG_PV        = 5'h0d;
  localparam logic [4:0] REG_DATE_LO   = 5'h0e;
  localparam logic [4:0] REG_DATE_HI   = 5'h0f;
  localparam logic [4:0] REG_AO        = 5'h10;

  // Control bit positions
  localparam int CTRL_SQRT_EN  = 0;
  localparam int CTRL_OVR_HIGH = 1;
  localparam int CTRL_HOLD_PRE = 2;
  localparam int CTRL_RATE_EN  = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_RANGE_MAX = 16'h0fa0;
  localparam logic [15:0] RST_RANGE_MIN = 16'h0000;
  localparam logic [15:0] RST_SV_UP     = 16'h7fff;
  localparam logic [15:0] RST_SV_LO     = 16'h8000;
  localparam logic [31:0] DATE_BLANK    = 32'hffff_ffff;

endpackage

// *** src/alarm_if.sv ***
// Interface: one limit alarm channel between the value path and its delay logic.
// Assumes all signals are synchronous to the block clock.
`timescale 1ns/10ps
interface alarm_if;
  logic        tick;
  logic        upper;
  logic [15:0] pv;
  logic [15:0] sv;
  logic [15:0] hyst;
  logic [7:0]  on_dly;
  logic [7:0]  off_dly;
  logic        alarm;
  modport ctrl (output tick, upper, pv, sv, hyst, on_dly, off_dly, input alarm);
  modport chan (input tick, upper, pv, sv, hyst, on_dly, off_dly, output alarm);
endinterface

// *** src/limit_alarm.sv ***
// Module: one limit alarm with on and off delays counted in conversions.
// Assumes tick marks a fresh signed process value on the interface.
`timescale 1ns/10ps
module limit_alarm (
  input  wire logic clk_sys,
  input  wire logic resetn,
  alarm_if.chan     a
);

  logic signed [17:0] pv_s;
  logic signed [17:0] sv_s;
  logic signed [17:0] hy_s;
  logic               cond_on;
  logic               cond_off;
  logic [7:0]         cnt_q;
  logic               alarm_q;

  // Two spare bits so set value plus or minus a large hysteresis cannot wrap
  assign pv_s = 18'(signed'(a.pv));
  assign sv_s = 18'(signed'(a.sv));
  assign hy_s = 18'(signed'({1'b0, a.hyst}));
  // Compare uses live set value, so a moved set point takes effect at once
  assign cond_on  = a.upper ? (pv_s > sv_s) : (pv_s < sv_s);
  assign cond_off = a.upper ? (pv_s < sv_s - hy_s) : (pv_s > sv_s + hy_s);

  // ****************************************
  // Delay counting
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_q   <= 8'h00;
      alarm_q <= 1'b0;
    end else if (a.tick) begin
      if (!alarm_q) begin
        if (!cond_on) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= a.on_dly) begin
          alarm_q <= 1'b1;
          cnt_q   <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end else begin
        if (!cond_off) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= a.off_dly) begin
          alarm_q <= 1'b0;
          cnt_q   <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  assign a.alarm = alarm_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_on_needs_cond;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(alarm_q) |-> $past(cond_on) && $past(a.tick) && ($past(cnt_q) >= $past(a.on_dly));
  endproperty
  a_on_needs_cond: assert property (p_on_needs_cond) else $error("alarm rose without held on condition");

  property p_off_needs_cond;
    @(posedge clk_sys) disable iff (!resetn)
      $fell(alarm_q) |-> $past(cond_off) && ($past(cnt_q) >= $past(a.off_dly));
  endproperty
  a_off_needs_cond: assert property (p_off_needs_cond) else $error("alarm cleared early");

  property p_cnt_restart;
    @(posedge clk_sys) disable iff (!resetn)
      a.tick && !alarm_q && !cond_on |=> cnt_q == 8'h00 && !alarm_q;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) else $error("on counter not restarted");

  property p_hyst_clear;
    @(posedge clk_sys) disable iff (!resetn)
      a.tick && alarm_q && !cond_off |=> alarm_q;
  endproperty
  a_hyst_clear: assert property (p_hyst_clear) else $error("alarm cleared inside hysteresis");

endmodule

// *** testbench/nv_store_model.sv ***
// Nonvolatile storage model: answers one date read after every reset.
// Assumes the bench picks the stored state with mode: 0 absent, 1 present, 2 faulty.
`timescale 1ns/10ps
module nv_store_model (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [1:0]  mode,
  input  wire logic [31:0] date,
  output logic             nv_done,
  output logic             nv_present,
  output logic             nv_fault,
  output logic [31:0]      nv_date
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
    end else if (cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Read finishes a few cycles after start-up, as a slow storage would
  assign nv_done    = (cnt_q == 3'h4);
  assign nv_present = (mode == 2'h1);
  assign nv_fault   = (mode == 2'h2);
  // Data lines are not held outside the answer cycle
  assign nv_date    = nv_done ? date : ~date;
endmodule

// *** testbench/tb_top.sv ***
// Testbench: drives the post-processing block by hand-written scenarios.
// Assumes the storage model beside it and a 50 MHz clock.
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, resetn, reg_wr, reg_rd, raw_valid, input_disconnect, host_fatal;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, raw_value, host_io_word_area, pv_out, analog_out;
  logic [1:0]  mode;
  logic nv_done, nv_present, nv_fault, uua, ua, la, lla, lamp, inr;
  logic [31:0] nv_date;
  int failures, compares, inrush_cnt;
  // ****************************************
  // Clock, reset and instances
  // ****************************************
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  nv_store_model nvm (.clk_sys(clk_sys), .resetn(resetn), .mode(mode), .date(32'h1234_5678),
    .nv_done(nv_done), .nv_present(nv_present), .nv_fault(nv_fault), .nv_date(nv_date));
  // Short output divider keeps the hold scenario brief
  process_value_alarm_scaling_logic #(.OUT_DIV(4)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .raw_valid(raw_valid), .raw_value(raw_value), .input_disconnect(input_disconnect),
    .host_fatal(host_fatal), .user_fatal_instruction(1'b0), .host_cpu_error(1'b0), .load_break(1'b0),
    .host_io_word_area(host_io_word_area), .nv_done(nv_done), .nv_present(nv_present),
    .nv_fault(nv_fault), .nv_date(nv_date), .pv_out(pv_out), .upper_upper_alarm(uua),
    .upper_alarm(ua), .lower_alarm(la), .lower_lower_alarm(lla), .inrush_start(inr),
    .analog_out(analog_out), .config_error_lamp(lamp));
  always @(posedge clk_sys) begin
    if (inr === 1'b1) inrush_cnt++;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic conv(input logic [15:0] r, input logic disc);
    @(posedge clk_sys);
    raw_valid <= 1'b1; raw_value <= r; input_disconnect <= disc;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic do_reset(input logic [1:0] m);
    mode <= m; resetn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic close_out;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_storage(input logic [1:0] m);
    logic [15:0] v;
    rd(5'h0e, v); chk("date_lo", (m == 2'h1) ? 16'h5678 : 16'hffff, v);
    rd(5'h0f, v); chk("date_hi", (m == 2'h1) ? 16'h1234 : 16'hffff, v);
    rd(5'h0c, v); chk("status", (m == 2'h2) ? 16'h03c0 : (m == 2'h1) ? 16'h0000 : 16'h0180, v & 16'h03c0);
    chk("lamp", {15'h0, m == 2'h2}, {15'h0, lamp});
    rd(5'h1f, v); chk("unmapped", 16'h0000, v);
    $display("storage test done");
  endtask
  task automatic t_scale;
    conv(16'h8000, 0); chk("pv_normal", 16'h07d0, pv_out);
    wr(5'h01, 16'h0000); wr(5'h02, 16'h0fa0);
    conv(16'h4000, 0); chk("pv_reversed", 16'h0bb8, pv_out);
    wr(5'h00, 16'h0002);
    conv(16'h4000, 1); chk("pv_disc_hi", 16'h0000, pv_out);
    wr(5'h00, 16'h0000);
    conv(16'h4000, 1); chk("pv_disc_lo", 16'h0fa0, pv_out);
    $display("scaling test done");
  endtask
  task automatic t_alarm;
    // Reversed range: low raw gives a high value, so the upper alarm trips on a low input
    wr(5'h04, 16'h0bb8); wr(5'h08, 16'h0002); wr(5'h09, 16'h0002);
    conv(16'h2000, 0); conv(16'h2000, 0); conv(16'h8000, 0);
    chk("alarm_early", 16'h0, {15'h0, ua});
    conv(16'h2000, 0); conv(16'h2000, 0); chk("alarm_two", 16'h0, {15'h0, ua});
    conv(16'h2000, 0); chk("alarm_on", 16'h1, {15'h0, ua});
    conv(16'h8000, 0); conv(16'h8000, 0); conv(16'h2000, 0);
    chk("alarm_hold", 16'h1, {15'h0, ua});
    repeat (3) conv(16'h8000, 0);
    chk("alarm_off", 16'h0, {15'h0, ua});
    chk("others", 16'h0, {13'h0, uua, la, lla});
    wr(5'h05, 16'h0fa0); repeat (3) conv(16'h8000, 0);
    chk("lower_on", 16'h1, {15'h0, la});
    $display("alarm test done");
  endtask
  task automatic t_hold;
    host_io_word_area <= 16'h0123;
    repeat (20) @(posedge clk_sys);
    chk("ao_host", 16'h0123, analog_out);
    host_fatal <= 1'b1; host_io_word_area <= 16'h0321;
    repeat (20) @(posedge clk_sys);
    chk("ao_prev", 16'h0123, analog_out);
    host_fatal <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("ao_back", 16'h0321, analog_out);
    wr(5'h0a, 16'h0055); wr(5'h00, 16'h0004); host_fatal <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("ao_preset", 16'h0055, analog_out);
    wr(5'h0b, 16'h0010); wr(5'h00, 16'h000c); wr(5'h0a, 16'h0015);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("ao_rate", 16'h0045, analog_out);
    repeat (20) @(posedge clk_sys);
    chk("ao_rate_end", 16'h0015, analog_out);
    host_fatal <= 1'b0;
    $display("hold test done");
  endtask
  task automatic t_inrush;
    chk("inrush_none", 16'h0000, 16'(inrush_cnt));
    wr(5'h00, 16'h0001);
    conv(16'h0100, 0); chk("pv_linear", 16'h000f, pv_out);
    conv(16'h0150, 0); chk("pv_sqrt", 16'h011e, pv_out);
    chk("inrush_once", 16'h0001, 16'(inrush_cnt));
    conv(16'h0100, 0); chk("pv_sqrt_hyst", 16'h00fa, pv_out);
    conv(16'h00c0, 0); chk("pv_back_linear", 16'h000b, pv_out);
    $display("square root and inrush test done");
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    failures = 0; compares = 0; inrush_cnt = 0;
    resetn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 5'h00; reg_wdata = 16'h0000;
    raw_valid = 0; raw_value = 16'h0000; input_disconnect = 0; host_fatal = 0;
    host_io_word_area = 16'h0000; mode = 2'h0;
    do_reset(2'h0);
    t_storage(2'h0);
    t_scale;
    t_alarm;
    t_hold;
    do_reset(2'h2);
    t_storage(2'h2);
    do_reset(2'h1);
    t_storage(2'h1);
    t_inrush;
    close_out;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    close_out;
  end
endmodule
